// [inc/axis_trig_pkg.sv]
// Purpose: Shared constants of the axis event trigger block.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Field positions are bit indices inside the register word.
package axis_trig_pkg;
   // ==========================================================
   // Sizes.
   localparam int AXES_DEF = 8;
   localparam int TASKS_DEF = 8;
   localparam int AXES_MAX = 8;
   localparam int TASKS_MAX = 8;
   localparam int ADDR_W = 8;
   localparam int INT_W = 17;
   // ==========================================================
   // Register offsets (byte addresses).
   localparam logic [7:0] OFS_TRIG_SET = 8'h00;
   localparam logic [7:0] OFS_EVENT_STATE = 8'h04;
   localparam logic [7:0] OFS_CYCLE = 8'h08;
   localparam logic [7:0] OFS_IDX_QUAL = 8'h0C;
   localparam logic [7:0] OFS_INT_STATUS = 8'h10;
   localparam logic [7:0] OFS_INT_MASK = 8'h14;
   localparam logic [7:0] OFS_ERR_WRITE = 8'h18;
   localparam logic [7:0] OFS_ERR_SEL = 8'h1C;
   localparam logic [7:0] OFS_ERR_STATE = 8'h20;
   // ==========================================================
   // Trigger setting codes, two bits per axis.
   localparam logic [1:0] SET_ZERO = 2'h0;
   localparam logic [1:0] SET_PLUS = 2'h1;
   localparam logic [1:0] SET_MINUS = 2'h3;
   // ==========================================================
   // Field positions.
   localparam int CYC_HOME_LSB = 0;
   localparam int CYC_REG_LSB = 8;
   localparam int CYC_FOL_LSB = 16;
   localparam int INT_TRAP_BIT = 16;
   localparam int ERRW_TASK_LSB = 0;
   localparam int ERRW_AXIS_LSB = 4;
   localparam int ERRW_NUM_LSB = 8;
   localparam int ERRW_REMOTE_BIT = 16;
   localparam int ERRS_TRAP_BIT = 16;
   // ==========================================================
   // Reset values.
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [3:0] AXIS_NONE = 4'h0;
endpackage

// [rtl/event_conditioner.sv]
// Purpose: Synchronise one pin and report its level and its edges.
// Assumes: The pin is asynchronous to MCLK.
// Notes: A change counts once the second and third stages agree.
`timescale 1ns/100ps
module event_conditioner (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Pin.
   input wire logic din_i,
   // Conditioned level and edge pulses.
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;
   wire agree = (s2_r == s3_r);

   // ==========================================================
   // Three-stage synchroniser; only the second stage reads the first.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_r <= 1'b0;
      end else begin
         s1_r <= din_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (agree) begin
            level_r <= s3_r;
         end
      end
   end

   // Edge pulses last one cycle, in the cycle before the level turns.
   assign rise_o = agree & s3_r & ~level_r;
   assign fall_o = agree & ~s3_r & level_r;
   assign level_o = level_r;
endmodule

// [rtl/axis_event_trigger_select.sv]
// Purpose: Per-axis event trigger conditioning, polarity and enable, plus task error records.
// Assumes: APB slave with one wait state; event and index pins are asynchronous.
// Notes: Axis number n is bit n-1 of every one-bit per-axis field; its trigger code sits at bits 2n-1:2n-2.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module axis_event_trigger_select #(
   parameter int AXES = axis_trig_pkg::AXES_DEF,
   parameter int TASKS = axis_trig_pkg::TASKS_DEF
) (
   // Clock and reset.
   input wire logic MCLK_I,
   input wire logic RST_I,
   // APB slave.
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [axis_trig_pkg::ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Axis pins.
   input wire logic [AXES-1:0] EVENT_I,
   input wire logic [AXES-1:0] INDEX_I,
   // Trigger, trap and interrupt outputs.
   output logic [AXES-1:0] HOME_TRIG_O,
   output logic [AXES-1:0] REG_INDEX_O,
   output logic [TASKS-1:0] TRAP_O,
   output logic IRQ_O
);
   // ==========================================================
   // Elaboration check.
   if (AXES < 1 || AXES > axis_trig_pkg::AXES_MAX || TASKS < 1 || TASKS > axis_trig_pkg::TASKS_MAX) begin : g_bad
      $error("AXES and TASKS must lie between one and eight.");
   end

   // ==========================================================
   // Declarations.
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [2*AXES-1:0] trig_code_r;
   wire [2*AXES-1:0] trig_code_nxt;
   logic [AXES-1:0] home_run_r;
   logic [AXES-1:0] regm_run_r;
   logic [AXES-1:0] fol_run_r;
   logic [AXES-1:0] idx_qual_r;
   logic [axis_trig_pkg::INT_W-1:0] sts_r;
   logic [axis_trig_pkg::INT_W-1:0] mask_r;
   logic [2:0] err_sel_r;
   logic irq_r;
   logic [AXES-1:0] home_trig_r;
   logic [AXES-1:0] reg_trig_r;
   wire [AXES-1:0] ev_level;
   wire [AXES-1:0] ev_rise;
   wire [AXES-1:0] ev_fall;
   wire [AXES-1:0] idx_rise;
   wire [AXES-1:0] code_zero;
   wire [AXES-1:0] code_minus;
   wire [AXES-1:0] home_fire;
   wire [AXES-1:0] reg_fire;
   wire [TASKS-1:0] trap_take;
   wire [TASKS-1:0] disarmed;
   wire [8*TASKS-1:0] err_num_all;
   wire [4*TASKS-1:0] err_axis_all;

   // ==========================================================
   // APB decode. One wait state lets read data come from a flop.
   wire access = PSEL_I & PENABLE_I;
   wire take = access & pready_r;
   wire wr_en = take & PWRITE_I;
   wire hit_trig = (PADDR_I == axis_trig_pkg::OFS_TRIG_SET);
   wire hit_state = (PADDR_I == axis_trig_pkg::OFS_EVENT_STATE);
   wire hit_cyc = (PADDR_I == axis_trig_pkg::OFS_CYCLE);
   wire hit_qual = (PADDR_I == axis_trig_pkg::OFS_IDX_QUAL);
   wire hit_sts = (PADDR_I == axis_trig_pkg::OFS_INT_STATUS);
   wire hit_mask = (PADDR_I == axis_trig_pkg::OFS_INT_MASK);
   wire hit_errw = (PADDR_I == axis_trig_pkg::OFS_ERR_WRITE);
   wire hit_esel = (PADDR_I == axis_trig_pkg::OFS_ERR_SEL);
   wire hit_est = (PADDR_I == axis_trig_pkg::OFS_ERR_STATE);
   wire addr_hit = hit_trig | hit_state | hit_cyc | hit_qual | hit_sts | hit_mask | hit_errw | hit_esel | hit_est;
   wire wr_trig = wr_en & hit_trig;
   wire wr_cyc = wr_en & hit_cyc;
   wire wr_qual = wr_en & hit_qual;
   wire wr_sts = wr_en & hit_sts;
   wire wr_mask = wr_en & hit_mask;
   wire wr_err = wr_en & hit_errw;
   wire wr_esel = wr_en & hit_esel;

   // ==========================================================
   // Selected task readback; an absent task reads as zero.
   wire sel_ok = ({29'h0, err_sel_r} < TASKS);
   wire [7:0] sel_num = sel_ok ? err_num_all[{err_sel_r, 3'h0} +: 8] : axis_trig_pkg::ERR_NONE;
   wire [3:0] sel_axis = sel_ok ? err_axis_all[{err_sel_r, 2'h0} +: 4] : axis_trig_pkg::AXIS_NONE;
   wire sel_dis = sel_ok ? disarmed[err_sel_r] : 1'b0;
   wire [31:0] err_state = {15'h0, sel_dis, 4'h0, sel_axis, sel_num};

   // Read multiplexer; unmapped addresses read zero and flag an error.
   wire [31:0] rd_mux = hit_trig ? 32'(trig_code_r) :
                        hit_state ? 32'(ev_level) :
                        hit_cyc ? {8'h0, 8'(fol_run_r), 8'(regm_run_r), 8'(home_run_r)} :
                        hit_qual ? 32'(idx_qual_r) :
                        hit_sts ? 32'(sts_r) :
                        hit_mask ? 32'(mask_r) :
                        hit_esel ? 32'(err_sel_r) :
                        hit_est ? err_state :
                        axis_trig_pkg::REG_RST;

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= axis_trig_pkg::REG_RST;
      end else begin
         pready_r <= access & ~pready_r;
         pslverr_r <= access & ~pready_r & ~addr_hit;
         if (access & ~pready_r) begin
            prdata_r <= rd_mux;
         end
      end
   end

   // ==========================================================
   // Register next values. A trigger clears its cycle bit ahead of any write.
   wire [AXES-1:0] reg_run = regm_run_r | fol_run_r;
   wire [AXES-1:0] home_run_nxt = (wr_cyc ? PWDATA_I[axis_trig_pkg::CYC_HOME_LSB +: AXES] : home_run_r) & ~home_fire;
   wire [AXES-1:0] regm_run_nxt = (wr_cyc ? PWDATA_I[axis_trig_pkg::CYC_REG_LSB +: AXES] : regm_run_r) & ~reg_fire;
   wire [AXES-1:0] fol_run_nxt = (wr_cyc ? PWDATA_I[axis_trig_pkg::CYC_FOL_LSB +: AXES] : fol_run_r) & ~reg_fire;
   wire [axis_trig_pkg::INT_W-1:0] sts_clr = wr_sts ? PWDATA_I[axis_trig_pkg::INT_W-1:0] : '0;
   wire [axis_trig_pkg::INT_W-1:0] int_set = {|trap_take, 8'(reg_fire), 8'(home_fire)};
   // Set wins over the write-one clear so an event in the clearing cycle survives.
   wire [axis_trig_pkg::INT_W-1:0] sts_nxt = (sts_r & ~sts_clr) | int_set;

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         trig_code_r <= '0;
         home_run_r <= '0;
         regm_run_r <= '0;
         fol_run_r <= '0;
         idx_qual_r <= '0;
         sts_r <= '0;
         mask_r <= '0;
         err_sel_r <= 3'h0;
         irq_r <= 1'b0;
         home_trig_r <= '0;
         reg_trig_r <= '0;
      end else begin
         trig_code_r <= trig_code_nxt;
         home_run_r <= home_run_nxt;
         regm_run_r <= regm_run_nxt;
         fol_run_r <= fol_run_nxt;
         if (wr_qual) begin
            idx_qual_r <= PWDATA_I[AXES-1:0];
         end
         sts_r <= sts_nxt;
         if (wr_mask) begin
            mask_r <= PWDATA_I[axis_trig_pkg::INT_W-1:0];
         end
         if (wr_esel) begin
            err_sel_r <= PWDATA_I[2:0];
         end
         irq_r <= |(sts_r & mask_r);
         home_trig_r <= home_fire;
         reg_trig_r <= reg_fire;
      end
   end

   // ==========================================================
   // Per-axis trigger logic.
   for (genvar a = 0; a < AXES; a++) begin : g_axis
      logic home_arm_r;
      logic reg_arm_r;
      wire [1:0] code = trig_code_r[2*a +: 2];
      wire [1:0] new_code = PWDATA_I[2*a +: 2];
      wire new_zero = (new_code != axis_trig_pkg::SET_PLUS) & (new_code != axis_trig_pkg::SET_MINUS);
      wire is_minus = (code == axis_trig_pkg::SET_MINUS);
      // Any code other than plus or minus one behaves as zero.
      assign code_zero[a] = ~is_minus & (code != axis_trig_pkg::SET_PLUS);
      assign code_minus[a] = is_minus;
      // A disabling write is dropped while a registration move runs.
      assign trig_code_nxt[2*a +: 2] = (wr_trig & ~(reg_run[a] & new_zero)) ? new_code : code;
      // Zero and plus both home on the active edge.
      wire home_edge = is_minus ? ev_fall[a] : ev_rise[a];
      wire reg_edge = code_zero[a] ? 1'b0 : (is_minus ? ev_fall[a] : ev_rise[a]);

      event_conditioner u_ev (
         .clk_i(MCLK_I),
         .rst_i(RST_I),
         .din_i(EVENT_I[a]),
         .level_o(ev_level[a]),
         .rise_o(ev_rise[a]),
         .fall_o(ev_fall[a])
      );
      event_conditioner u_idx (
         .clk_i(MCLK_I),
         .rst_i(RST_I),
         .din_i(INDEX_I[a]),
         .level_o(),
         .rise_o(idx_rise[a]),
         .fall_o()
      );

      // With index qualification the event only arms; the next index edge fires.
      always_ff @(posedge MCLK_I) begin
         if (RST_I | ~home_run_r[a] | home_fire[a]) begin
            home_arm_r <= 1'b0;
         end else if (home_edge) begin
            home_arm_r <= 1'b1;
         end
      end
      always_ff @(posedge MCLK_I) begin
         if (RST_I | ~reg_run[a] | reg_fire[a]) begin
            reg_arm_r <= 1'b0;
         end else if (reg_edge) begin
            reg_arm_r <= 1'b1;
         end
      end
      assign home_fire[a] = home_run_r[a] & (idx_qual_r[a] ? (home_arm_r & idx_rise[a]) : home_edge);
      assign reg_fire[a] = reg_run[a] & (idx_qual_r[a] ? (reg_arm_r & idx_rise[a]) : reg_edge);
   end

   // ==========================================================
   // Per-task error records.
   wire [2:0] ew_task = PWDATA_I[axis_trig_pkg::ERRW_TASK_LSB +: 3];
   wire [7:0] ew_num = PWDATA_I[axis_trig_pkg::ERRW_NUM_LSB +: 8];
   wire ew_remote = PWDATA_I[axis_trig_pkg::ERRW_REMOTE_BIT];
   // A remote trap names no axis, so its recorded axis reads zero.
   wire [3:0] ew_axis = ew_remote ? axis_trig_pkg::AXIS_NONE : PWDATA_I[axis_trig_pkg::ERRW_AXIS_LSB +: 4];

   for (genvar t = 0; t < TASKS; t++) begin : g_task
      logic [7:0] num_r;
      logic [3:0] axis_r;
      logic dis_r;
      wire sel = wr_err & (ew_task == 3'(t));
      wire clr = sel & (ew_num == axis_trig_pkg::ERR_NONE);
      // A disarmed task ignores new errors until it is cleared.
      assign trap_take[t] = sel & (ew_num != axis_trig_pkg::ERR_NONE) & ~dis_r;
      always_ff @(posedge MCLK_I) begin
         if (RST_I | clr) begin
            num_r <= axis_trig_pkg::ERR_NONE;
            axis_r <= axis_trig_pkg::AXIS_NONE;
            dis_r <= 1'b0;
         end else if (trap_take[t]) begin
            num_r <= ew_num;
            axis_r <= ew_axis;
            dis_r <= 1'b1;
         end
      end
      assign err_num_all[8*t +: 8] = num_r;
      assign err_axis_all[4*t +: 4] = axis_r;
      assign disarmed[t] = dis_r;

      chk_trap_loads_number: assert property (@(posedge MCLK_I) disable iff (RST_I)
         trap_take[t] |=> (num_r == $past(ew_num)) && dis_r) else $error("Trap did not load its number.");
      chk_disarmed_holds_error: assert property (@(posedge MCLK_I) disable iff (RST_I)
         (dis_r && !clr) |=> $stable(num_r) && dis_r) else $error("Disarmed task changed its error.");
      chk_remote_axis_zero: assert property (@(posedge MCLK_I) disable iff (RST_I)
         (trap_take[t] && ew_remote) |=> (axis_r == 4'h0)) else $error("Remote trap recorded an axis.");
      // Writing zero must rearm the task and wipe its axis number as well.
      chk_clear_rearms: assert property (@(posedge MCLK_I) disable iff (RST_I)
         clr |=> (num_r == axis_trig_pkg::ERR_NONE) && (axis_r == axis_trig_pkg::AXIS_NONE) && !dis_r)
         else $error("Clearing write did not rearm the task.");
   end

   // ==========================================================
   // Outputs.
   assign PRDATA_O = prdata_r;
   assign PREADY_O = pready_r;
   assign PSLVERR_O = pslverr_r;
   assign HOME_TRIG_O = home_trig_r;
   assign REG_INDEX_O = reg_trig_r;
   assign TRAP_O = disarmed;
   assign IRQ_O = irq_r;

   // ==========================================================
   // Assertions.
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RST_I);

   wire [AXES-1:0] zero_home = home_run_r & ~idx_qual_r & ev_rise & code_zero;
   wire [AXES-1:0] qual_wait = idx_qual_r & ~idx_rise;
   wire rd_state = take & ~PWRITE_I & hit_state;
   // The edge that the present code selects; zero homes like plus.
   wire [AXES-1:0] pol_edge = (code_minus & ev_fall) | (~code_minus & ev_rise);
   wire [AXES-1:0] plain_miss = ~idx_qual_r & ~pol_edge;

   chk_home_needs_cycle: assert property ((home_trig_r & ~$past(home_run_r)) == '0)
      else $error("Home trigger outside a home cycle.");
   chk_home_zero_armed: assert property ((home_trig_r & $past(zero_home)) == $past(zero_home))
      else $error("Zero setting blocked the home trigger.");
   chk_home_right_edge: assert property ((home_trig_r & $past(plain_miss)) == '0)
      else $error("Home trigger took the wrong edge.");
   // A trigger clears its own cycle bit, so each cycle gives one pulse.
   chk_home_ends_cycle: assert property ((home_trig_r & home_run_r) == '0)
      else $error("Home trigger did not end the home cycle.");
   chk_reg_zero_off: assert property ((reg_trig_r & $past(code_zero)) == '0)
      else $error("Registration fired with a zero setting.");
   chk_disable_ignored: assert property ((code_zero & ~$past(code_zero) & $past(reg_run)) == '0)
      else $error("Trigger was disabled during a registration move.");
   chk_reg_ends_move: assert property ((reg_trig_r & (regm_run_r | fol_run_r)) == '0)
      else $error("Registration trigger did not end the move.");
   chk_reg_needs_run: assert property ((reg_trig_r & ~$past(reg_run)) == '0)
      else $error("Registration trigger outside a registration move.");
   chk_reg_pulse_once: assert property ((reg_trig_r != '0) |=> ((reg_trig_r & $past(reg_trig_r)) == '0))
      else $error("Registration trigger repeated.");
   chk_index_qualifies: assert property (((home_trig_r | reg_trig_r) & $past(qual_wait)) == '0)
      else $error("Qualified trigger fired without an index edge.");
   chk_state_readback: assert property (rd_state |-> (PRDATA_O[AXES-1:0] == $past(ev_level)))
      else $error("Event state readback is wrong.");
   chk_reg_minus_edge: assert property ((reg_trig_r & $past(plain_miss)) == '0)
      else $error("Registration trigger took the wrong edge.");
   chk_irq_level: assert property ((sts_r & mask_r) != '0 |=> IRQ_O) else $error("Interrupt missing.");
   chk_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O) else $error("Ready held too long.");

   // Unmapped offsets must answer with an error, never with stale data.
   chk_slverr_unmapped: assert property (take |-> (PSLVERR_O == !addr_hit))
      else $error("Bus error flag is wrong.");
   // An event in the clearing cycle must survive, or software would lose it.
   chk_sts_set_wins: assert property ((sts_r & $past(int_set)) == $past(int_set))
      else $error("Status event was lost.");
   chk_trap_sets_status: assert property ((trap_take != '0) |=> sts_r[axis_trig_pkg::INT_TRAP_BIT])
      else $error("Trap did not set its status bit.");

   // Covers show that each trigger path and the write lock were reached.
   cov_home_fire: cover property (home_trig_r != '0);
   cov_reg_fire: cover property (reg_trig_r != '0);
   cov_qual_fire: cover property ((reg_trig_r & $past(idx_qual_r)) != '0);
   cov_trap: cover property (trap_take != '0);
   cov_lock_write: cover property (wr_trig && (reg_run != '0));
endmodule

// [test/event_sensor.sv]
// Purpose: Behavioural switch or sensor wired to the axis event pins.
// Assumes: One pin per axis, always driven, never floating.
// Notes: The slow pace mimics a switch with a long contact delay.
`timescale 1ns/100ps
module event_sensor (
   // Clock.
   input wire logic clk_i,
   // Requested levels and pace.
   input wire logic [7:0] want_i,
   input wire logic slow_i,
   // Pins.
   output logic [7:0] pin_o
);
   // ==========================================================
   // Delay line.
   logic [7:0] dly_r [0:5];
   initial begin
      for (int i = 0; i < 6; i++) begin
         dly_r[i] = 8'h00;
      end
   end
   always @(posedge clk_i) begin
      dly_r[0] <= want_i;
      for (int i = 1; i < 6; i++) begin
         dly_r[i] <= dly_r[i-1];
      end
   end
   assign pin_o = slow_i ? dly_r[5] : dly_r[0];
endmodule

// [test/tb_top.sv]
// Purpose: Self-checking bench of the axis event trigger block.
// Assumes: APB answers with one wait state; pin edges are spaced well apart.
// Notes: Trigger pulses are caught by sticky monitors, so no single cycle is missed.
`timescale 1ns/100ps
module tb_top;
   // ==========================================================
   // Signals.
   logic MCLK_I = 1'b0;
   logic RST_I = 1'b1;
   logic PSEL_I = 1'b0;
   logic PENABLE_I = 1'b0;
   logic PWRITE_I = 1'b0;
   logic [7:0] PADDR_I = 8'h00;
   logic [31:0] PWDATA_I = 32'h0000_0000;
   logic [31:0] PRDATA_O;
   logic PREADY_O;
   logic PSLVERR_O;
   logic [7:0] EVENT_I;
   logic [7:0] INDEX_I = 8'h00;
   logic [7:0] HOME_TRIG_O;
   logic [7:0] REG_INDEX_O;
   logic [7:0] TRAP_O;
   logic IRQ_O;
   logic [7:0] want = 8'h00;
   logic slow = 1'b0;
   logic clr_seen = 1'b0;
   logic [7:0] home_seen = 8'h00;
   logic [7:0] reg_seen = 8'h00;
   logic [31:0] rd;
   logic err;
   int err_total = 0;
   int samples_checked = 0;
   // ==========================================================
   // Instances.
   axis_event_trigger_select dut_u (.MCLK_I(MCLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
      .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
      .PSLVERR_O(PSLVERR_O), .EVENT_I(EVENT_I), .INDEX_I(INDEX_I), .HOME_TRIG_O(HOME_TRIG_O),
      .REG_INDEX_O(REG_INDEX_O), .TRAP_O(TRAP_O), .IRQ_O(IRQ_O));
   event_sensor sensor_u (.clk_i(MCLK_I), .want_i(want), .slow_i(slow), .pin_o(EVENT_I));
   initial begin
      forever #2 MCLK_I = ~MCLK_I;
   end
   always @(posedge MCLK_I) begin
      home_seen <= clr_seen ? 8'h00 : (home_seen | HOME_TRIG_O);
      reg_seen <= clr_seen ? 8'h00 : (reg_seen | REG_INDEX_O);
   end
   // ==========================================================
   // Shared tasks.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge MCLK_I);
      PSEL_I <= 1'b1;
      PWRITE_I <= wr;
      PADDR_I <= a;
      PWDATA_I <= wd;
      @(posedge MCLK_I);
      PENABLE_I <= 1'b1;
      // Only the watchdog ends a wait, so a slow answer is never cut short.
      do begin
         @(posedge MCLK_I);
      end while (PREADY_O !== 1'b1);
      rd = PRDATA_O;
      err = PSLVERR_O;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
   endtask
   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask
   task automatic settle(input logic [7:0] lvl);
      want <= lvl;
      repeat (16) @(posedge MCLK_I);
   endtask
   task automatic clear_seen();
      @(posedge MCLK_I);
      clr_seen <= 1'b1;
      @(posedge MCLK_I);
      clr_seen <= 1'b0;
   endtask
   task automatic print_verdict();
      if (err_total == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios.
   task automatic t_reset();
      rd_check(axis_trig_pkg::OFS_TRIG_SET, axis_trig_pkg::REG_RST);
      rd_check(axis_trig_pkg::OFS_CYCLE, axis_trig_pkg::REG_RST);
      rd_check(axis_trig_pkg::OFS_ERR_STATE, axis_trig_pkg::REG_RST);
      rd_check(8'h40, 32'h0000_0000);
      check({31'h0, err}, 32'h0000_0001);
   endtask
   task automatic t_state();
      settle(8'hA5);
      rd_check(axis_trig_pkg::OFS_EVENT_STATE, 32'h0000_00A5);
      settle(8'h00);
      rd_check(axis_trig_pkg::OFS_EVENT_STATE, 32'h0000_0000);
   endtask
   // Home on axis 3 with each code; zero must still arm the trigger.
   task automatic t_home();
      logic [1:0] codes [3];
      logic idle;
      codes = '{axis_trig_pkg::SET_ZERO, axis_trig_pkg::SET_PLUS, axis_trig_pkg::SET_MINUS};
      for (int i = 0; i < 3; i++) begin
         idle = (codes[i] == axis_trig_pkg::SET_MINUS);
         slow <= idle;
         settle({5'h00, idle, 2'h0});
         apb(1'b1, axis_trig_pkg::OFS_TRIG_SET, {26'h0, codes[i], 4'h0});
         apb(1'b1, axis_trig_pkg::OFS_CYCLE, 32'h0000_0004 << axis_trig_pkg::CYC_HOME_LSB);
         clear_seen();
         settle({5'h00, ~idle, 2'h0});
         check({24'h0, home_seen}, 32'h0000_0004);
         rd_check(axis_trig_pkg::OFS_CYCLE, 32'h0000_0000);
      end
      slow <= 1'b0;
      settle(8'h00);
   endtask
   // Registration on axis 5: zero, plus on a move, minus on a follower move.
   task automatic t_reg();
      logic [1:0] codes [3];
      int lsb;
      logic [31:0] run;
      codes = '{axis_trig_pkg::SET_ZERO, axis_trig_pkg::SET_PLUS, axis_trig_pkg::SET_MINUS};
      for (int i = 0; i < 3; i++) begin
         lsb = (i == 2) ? axis_trig_pkg::CYC_FOL_LSB : axis_trig_pkg::CYC_REG_LSB;
         run = 32'h0000_0010 << lsb;
         settle((i == 2) ? 8'h10 : 8'h00);
         apb(1'b1, axis_trig_pkg::OFS_TRIG_SET, {22'h0, codes[i], 8'h00});
         apb(1'b1, axis_trig_pkg::OFS_CYCLE, run);
         clear_seen();
         settle((i == 2) ? 8'h00 : 8'h10);
         check({24'h0, reg_seen}, (i == 0) ? 32'h0 : 32'h0000_0010);
         rd_check(axis_trig_pkg::OFS_CYCLE, (i == 0) ? run : 32'h0);
         apb(1'b1, axis_trig_pkg::OFS_CYCLE, 32'h0000_0000);
      end
      settle(8'h00);
   endtask
   task automatic t_lock();
      apb(1'b1, axis_trig_pkg::OFS_TRIG_SET, 32'h0000_0100);
      apb(1'b1, axis_trig_pkg::OFS_CYCLE, 32'h0000_0010 << axis_trig_pkg::CYC_REG_LSB);
      apb(1'b1, axis_trig_pkg::OFS_TRIG_SET, 32'h0000_0000);
      rd_check(axis_trig_pkg::OFS_TRIG_SET, 32'h0000_0100);
      apb(1'b1, axis_trig_pkg::OFS_TRIG_SET, 32'h0000_0300);
      rd_check(axis_trig_pkg::OFS_TRIG_SET, 32'h0000_0300);
      apb(1'b1, axis_trig_pkg::OFS_CYCLE, 32'h0000_0000);
   endtask
   // Axis 1 waits for the index pulse once qualified: home first, then registration.
   task automatic t_index();
      apb(1'b1, axis_trig_pkg::OFS_TRIG_SET, 32'h0000_0001);
      apb(1'b1, axis_trig_pkg::OFS_IDX_QUAL, 32'h0000_0001);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, axis_trig_pkg::OFS_CYCLE, (i == 0) ? 32'h0000_0001 : 32'h0000_0100);
         clear_seen();
         settle(8'h01);
         check({16'h0, reg_seen, home_seen}, 32'h0000_0000);
         INDEX_I <= 8'h01;
         repeat (4) @(posedge MCLK_I);
         INDEX_I <= 8'h00;
         repeat (12) @(posedge MCLK_I);
         check({16'h0, reg_seen, home_seen}, (i == 0) ? 32'h0000_0001 : 32'h0000_0100);
         settle(8'h00);
      end
   endtask
   task automatic t_irq();
      apb(1'b1, axis_trig_pkg::OFS_INT_MASK, 32'h0000_0000);
      repeat (3) @(posedge MCLK_I);
      check({31'h0, IRQ_O}, 32'h0000_0000);
      apb(1'b1, axis_trig_pkg::OFS_INT_MASK, 32'h0000_0004);
      repeat (3) @(posedge MCLK_I);
      check({31'h0, IRQ_O}, 32'h0000_0001);
      apb(1'b1, axis_trig_pkg::OFS_INT_STATUS, 32'h0000_0004);
      repeat (3) @(posedge MCLK_I);
      check({31'h0, IRQ_O}, 32'h0000_0000);
      apb(1'b0, axis_trig_pkg::OFS_INT_STATUS, 32'h0000_0000);
      check(rd & 32'h0000_0004, 32'h0000_0000);
   endtask
   task automatic t_err();
      apb(1'b1, axis_trig_pkg::OFS_ERR_WRITE, 32'h0000_1A32);
      apb(1'b1, axis_trig_pkg::OFS_ERR_SEL, 32'h0000_0002);
      rd_check(axis_trig_pkg::OFS_ERR_STATE, 32'h0001_031A);
      check({24'h0, TRAP_O}, 32'h0000_0004);
      apb(1'b1, axis_trig_pkg::OFS_ERR_WRITE, 32'h0000_3352);
      rd_check(axis_trig_pkg::OFS_ERR_STATE, 32'h0001_031A);
      apb(1'b1, axis_trig_pkg::OFS_ERR_WRITE, 32'h0000_0002);
      rd_check(axis_trig_pkg::OFS_ERR_STATE, 32'h0000_0000);
      apb(1'b1, axis_trig_pkg::OFS_ERR_WRITE, 32'h0001_3745);
      apb(1'b1, axis_trig_pkg::OFS_ERR_SEL, 32'h0000_0005);
      rd_check(axis_trig_pkg::OFS_ERR_STATE, 32'h0001_0037);
      check({24'h0, TRAP_O}, 32'h0000_0020);
   endtask
   // ==========================================================
   // Main sequence and watchdog.
   initial begin
      repeat (2) @(posedge MCLK_I);
      RST_I <= 1'b0;
      @(posedge MCLK_I);
      t_reset();
      t_state();
      t_home();
      t_reg();
      t_lock();
      t_index();
      t_irq();
      t_err();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge MCLK_I);
      err_total++;
      print_verdict();
   end
endmodule
